// [rtl/ivc_pkg.sv]
/*
 * Constants, register map and types of the interrupt and vector controller.
 * Assumes an AXI4-Lite master in front and a CPU core that stacks and fetches as told.
 */
// What this block does
// - Exception sequence starts only at an instruction boundary after acceptance.
// - Push PC and flags; in maximum mode push code bank first.
// - Fetch two-byte vector entry and load it into the program counter.
// - Reset vector 000000H, zero division 000002H, watchdog NMI 000004H.
// - Peripheral vectors 000006H to 000022H in fixed factor order.
// - Default priority follows vector address order, reset highest.
// - 000024H reserved; 000026H to 0000FEH are unrated software interrupts.
// - Each system has a 2-bit read/write priority field, levels 0 to 3.
// - Each factor has an enable bit; one permits, zero blocks.
// - Factor flags set on events; writing one clears, zero leaves unchanged.
// - Request stays asserted while its flag and its enable bit are both set.
// - Lowering core mask with flag still set raises the interrupt again.
// - Accept needs flag set, enable set, priority above core mask.
// - Watchdog NMI is level 4 and is always accepted.
// - Equal levels resolve by fixed default priority order.
// - Mask loads accepted level, 3 for NMI, restored on return.
package ivc_pkg;

	localparam logic [15:0] IDX_PRIO_A  = 16'hff20;
	localparam logic [15:0] IDX_PRIO_B  = 16'hff21;
	localparam logic [15:0] IDX_EN_A    = 16'hff22;
	localparam logic [15:0] IDX_EN_B    = 16'hff23;
	localparam logic [15:0] IDX_FLAG_A  = 16'hff24;
	localparam logic [15:0] IDX_FLAG_B  = 16'hff25;

	localparam logic [7:0]  PRIO_A_RST  = 8'h00;
	localparam logic [3:0]  PRIO_B_RST  = 4'h0;
	localparam logic [14:0] EN_RST      = 15'h0000;
	localparam logic [14:0] FLAG_RST    = 15'h0000;
	localparam logic [1:0]  CORE_MASK_RST = 2'h3;

	localparam logic [7:0]  VEC_RESET   = 8'h00;
	localparam logic [7:0]  VEC_ZDIV    = 8'h02;
	localparam logic [7:0]  VEC_NMI     = 8'h04;
	localparam logic [7:0]  VEC_PERIPH  = 8'h06;
	localparam logic [7:0]  VEC_SWI_LO  = 8'h26;
	localparam logic [3:0]  TOP_FACTOR  = 4'he;

	localparam logic [1:0]  PUSH_CB     = 2'h0;
	localparam logic [1:0]  PUSH_PC     = 2'h1;
	localparam logic [1:0]  PUSH_SC     = 2'h2;
	localparam logic [2:0]  LVL_NMI     = 3'h4;

	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		S_RESET,
		S_IDLE,
		S_PUSH_CB,
		S_PUSH_PC,
		S_PUSH_SC,
		S_FETCH_LO,
		S_FETCH_HI,
		S_LOAD
	} ivc_state_t;

endpackage : ivc_pkg

// [rtl/ivc_top.sv]
/*
 * Interrupt factor flags, enables, priorities, arbitration and exception sequencer.
 * Assumes a core that returns vector bytes one cycle after fetch_valid and
 * signals instruction boundaries, returns and its own mask writes.
 */
`timescale 1ns/100ps

module ivc_top #(
	parameter int ADDR_W    = 18,
	parameter int STK_DEPTH = 4
) (
	input  wire logic                aclk,
	input  wire logic                aresetn,
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	output logic [1:0]               s_axi_bresp,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	input  wire logic [ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	input  wire logic [14:0]         factor_evt,
	input  wire logic                nmi_evt,
	input  wire logic                zdiv_evt,
	input  wire logic                swi_evt,
	input  wire logic [7:0]          swi_vec,
	input  wire logic                instr_done,
	input  wire logic                max_mode,
	input  wire logic                return_from_exception,
	input  wire logic                core_mask_wr,
	input  wire logic [1:0]          core_mask_wdata,
	input  wire logic [7:0]          fetch_rdata,
	output logic [1:0]               core_mask,
	output logic                     irq,
	output logic [2:0]               req_level,
	output logic                     push_valid,
	output logic [1:0]               push_sel,
	output logic                     fetch_valid,
	output logic [23:0]              fetch_addr,
	output logic                     pc_load,
	output logic [15:0]              pc_value
);
	import ivc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [15:0] idx_of(input logic [ADDR_W-1:0] a);
		idx_of = a[17:2];
	endfunction : idx_of

	// Factor bit 14 is timer 1 (highest), bit 0 the clock timer 1 Hz
	function automatic logic [1:0] level_of(input int b, input logic [7:0] pa, input logic [3:0] pb);
		if (b >= 13) begin
			level_of = pb[3:2];
		end else if (b == 12) begin
			level_of = pb[1:0];
		end else if (b >= 10) begin
			level_of = pa[7:6];
		end else if (b >= 7) begin
			level_of = pa[5:4];
		end else if (b >= 4) begin
			level_of = pa[3:2];
		end else begin
			level_of = pa[1:0];
		end
	endfunction : level_of

	// Strict compare keeps the first hit, so ties go to the higher default slot
	function automatic logic [6:0] pick(input logic [14:0] pend, input logic [7:0] pa, input logic [3:0] pb);
		logic       found;
		logic [1:0] lvl;
		logic [3:0] idx;
		found = 1'b0;
		lvl   = 2'h0;
		idx   = 4'h0;
		for (int b = 14; b >= 0; b--) begin
			if (pend[b] && (!found || level_of(b, pa, pb) > lvl)) begin
				found = 1'b1;
				lvl   = level_of(b, pa, pb);
				idx   = 4'(b);
			end
		end
		pick = {found, lvl, idx};
	endfunction : pick

	////////////////////////////////////////////////////////////////////////
	// State

	logic [7:0]          prio_a_r;
	logic [3:0]          prio_b_r;
	logic [14:0]         en_r;
	logic [14:0]         flag_r;
	logic [ADDR_W-1:0]   waddr_r;
	logic [7:0]          wbyte_r;
	logic                wlane_r;
	logic                nmi_pend_r;
	logic                zdiv_pend_r;
	logic                swi_pend_r;
	logic [7:0]          swi_vec_r;
	logic [1:0]          mask_r;
	logic [1:0]          mask_stk_r [STK_DEPTH];
	logic [2:0]          sp_r;
	logic [7:0]          vec_r;
	logic [7:0]          lo_r;
	ivc_state_t          state_r;

	////////////////////////////////////////////////////////////////////////
	// Register decode

	wire logic [15:0] widx    = idx_of(waddr_r);
	wire logic [15:0] ridx    = idx_of(s_axi_araddr);
	wire logic        wr_go   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire logic        wr_ok   = (widx >= IDX_PRIO_A) && (widx <= IDX_FLAG_B);
	wire logic        wr_en   = wr_go && wr_ok && wlane_r;
	wire logic        wr_pa   = wr_en && (widx == IDX_PRIO_A);
	wire logic        wr_pb   = wr_en && (widx == IDX_PRIO_B);
	wire logic        wr_ea   = wr_en && (widx == IDX_EN_A);
	wire logic        wr_eb   = wr_en && (widx == IDX_EN_B);
	wire logic        wr_fa   = wr_en && (widx == IDX_FLAG_A);
	wire logic        wr_fb   = wr_en && (widx == IDX_FLAG_B);
	wire logic        rd_ok   = (ridx >= IDX_PRIO_A) && (ridx <= IDX_FLAG_B);

	// Unused positions read as zero
	wire logic [7:0]  rd_byte =
		(ridx == IDX_PRIO_A) ? prio_a_r :
		(ridx == IDX_PRIO_B) ? {4'h0, prio_b_r} :
		(ridx == IDX_EN_A)   ? {1'b0, en_r[6:0]} :
		(ridx == IDX_EN_B)   ? en_r[14:7] :
		(ridx == IDX_FLAG_A) ? {1'b0, flag_r[6:0]} :
		(ridx == IDX_FLAG_B) ? flag_r[14:7] : 8'h00;

	wire logic [14:0] flag_clr = {wr_fb ? wbyte_r : 8'h00, wr_fa ? wbyte_r[6:0] : 7'h00};
	// A new event beats a clear in the same cycle
	wire logic [14:0] flag_nxt = (flag_r & ~flag_clr) | factor_evt;

	////////////////////////////////////////////////////////////////////////
	// Arbitration

	wire logic [14:0] pend     = flag_r & en_r;
	wire logic [6:0]  win      = pick(pend, prio_a_r, prio_b_r);
	wire logic        win_any  = win[6];
	wire logic [1:0]  win_lvl  = win[5:4];
	wire logic [3:0]  win_idx  = win[3:0];
	// Level 0 never beats any mask; the mask is re-read each boundary
	wire logic        irq_take = win_any && (win_lvl > mask_r);
	wire logic [7:0]  win_vec  = VEC_PERIPH + {3'h0, TOP_FACTOR - win_idx, 1'b0};
	wire logic        swi_ok   = (swi_vec >= VEC_SWI_LO) && !swi_vec[0];
	wire logic        accept   = (state_r == S_IDLE) && instr_done &&
		(zdiv_pend_r || nmi_pend_r || irq_take || swi_pend_r);
	wire logic        stk_full = (sp_r == 3'(STK_DEPTH));
	wire logic        do_ret   = return_from_exception && (sp_r != 3'h0) && !accept;
	wire logic [2:0]  sp_dec   = sp_r - 3'h1;

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			waddr_r       <= '0;
			wbyte_r       <= 8'h00;
			wlane_r       <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				waddr_r       <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wbyte_r      <= s_axi_wdata[7:0];
				wlane_r      <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h00_0000, rd_byte};
			s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control registers

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prio_a_r <= PRIO_A_RST;
			prio_b_r <= PRIO_B_RST;
			en_r     <= EN_RST;
			flag_r   <= FLAG_RST;
			irq      <= 1'b0;
		end else begin
			if (wr_pa) begin
				prio_a_r <= wbyte_r;
			end
			if (wr_pb) begin
				prio_b_r <= wbyte_r[3:0];
			end
			if (wr_ea) begin
				en_r[6:0] <= wbyte_r[6:0];
			end
			if (wr_eb) begin
				en_r[14:7] <= wbyte_r;
			end
			flag_r <= flag_nxt;
			irq    <= |pend;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Synchronous exception requests

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nmi_pend_r  <= 1'b0;
			zdiv_pend_r <= 1'b0;
			swi_pend_r  <= 1'b0;
			swi_vec_r   <= 8'h00;
			req_level   <= 3'h0;
		end else begin
			if (accept && zdiv_pend_r) begin
				zdiv_pend_r <= 1'b0;
			end else if (accept && nmi_pend_r) begin
				nmi_pend_r <= 1'b0;
			end else if (accept && !irq_take && swi_pend_r) begin
				swi_pend_r <= 1'b0;
			end
			if (zdiv_evt) begin
				zdiv_pend_r <= 1'b1;
			end
			if (nmi_evt) begin
				nmi_pend_r <= 1'b1;
			end
			// Reserved and odd vectors are dropped, a pending one is kept
			if (swi_evt && swi_ok && !swi_pend_r) begin
				swi_pend_r <= 1'b1;
				swi_vec_r  <= swi_vec;
			end
			req_level <= (nmi_pend_r || nmi_evt) ? LVL_NMI : (win_any ? {1'b0, win_lvl} : 3'h0);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Core mask with its return stack

	// A full stack keeps the outer entries; nesting beyond its depth loses the newest return
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_r <= CORE_MASK_RST;
			sp_r   <= 3'h0;
			for (int i = 0; i < STK_DEPTH; i++) begin
				mask_stk_r[i] <= 2'h0;
			end
		end else if (accept) begin
			if (!stk_full) begin
				mask_stk_r[sp_r[1:0]] <= mask_r;
				sp_r                  <= sp_r + 3'h1;
			end
			if (zdiv_pend_r) begin
				mask_r <= mask_r;
			end else if (nmi_pend_r) begin
				mask_r <= 2'h3;
			end else if (irq_take) begin
				mask_r <= win_lvl;
			end
		end else if (do_ret) begin
			mask_r <= mask_stk_r[sp_dec[1:0]];
			sp_r   <= sp_dec;
		end else if (core_mask_wr) begin
			mask_r <= core_mask_wdata;
		end
	end

	assign core_mask = mask_r;

	////////////////////////////////////////////////////////////////////////
	// Exception sequencer

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r     <= S_RESET;
			vec_r       <= VEC_RESET;
			lo_r        <= 8'h00;
			push_valid  <= 1'b0;
			push_sel    <= PUSH_CB;
			fetch_valid <= 1'b0;
			fetch_addr  <= 24'h00_0000;
			pc_load     <= 1'b0;
			pc_value    <= 16'h0000;
		end else begin
			push_valid  <= 1'b0;
			fetch_valid <= 1'b0;
			pc_load     <= 1'b0;
			case (state_r)
				S_RESET: begin
					state_r     <= S_FETCH_LO;
					fetch_valid <= 1'b1;
					fetch_addr  <= {16'h0000, vec_r};
				end
				S_IDLE: begin
					if (accept) begin
						// Fixed order: zero division, NMI, peripherals, then software
						if (zdiv_pend_r) begin
							vec_r <= VEC_ZDIV;
						end else if (nmi_pend_r) begin
							vec_r <= VEC_NMI;
						end else if (irq_take) begin
							vec_r <= win_vec;
						end else begin
							vec_r <= swi_vec_r;
						end
						push_valid <= 1'b1;
						push_sel   <= max_mode ? PUSH_CB : PUSH_PC;
						state_r    <= max_mode ? S_PUSH_CB : S_PUSH_PC;
					end
				end
				S_PUSH_CB: begin
					push_valid <= 1'b1;
					push_sel   <= PUSH_PC;
					state_r    <= S_PUSH_PC;
				end
				S_PUSH_PC: begin
					push_valid <= 1'b1;
					push_sel   <= PUSH_SC;
					state_r    <= S_PUSH_SC;
				end
				S_PUSH_SC: begin
					fetch_valid <= 1'b1;
					fetch_addr  <= {16'h0000, vec_r};
					state_r     <= S_FETCH_LO;
				end
				S_FETCH_LO: begin
					fetch_valid <= 1'b1;
					fetch_addr  <= {16'h0000, vec_r + 8'h01};
					state_r     <= S_FETCH_HI;
				end
				S_FETCH_HI: begin
					lo_r    <= fetch_rdata;
					state_r <= S_LOAD;
				end
				S_LOAD: begin
					pc_load  <= 1'b1;
					pc_value <= {fetch_rdata, lo_r};
					state_r  <= S_IDLE;
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

endmodule : ivc_top

// [verif/ivc_asserts.sv]
/* Port checks of the interrupt vector controller.
   Bound to ivc_top from the bench; sees its ports only. */
`timescale 1ns/100ps

module ivc_asserts
	import ivc_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        instr_done,
	input wire logic        max_mode,
	input wire logic [7:0]  fetch_rdata,
	input wire logic        irq,
	input wire logic [2:0]  req_level,
	input wire logic        push_valid,
	input wire logic [1:0]  push_sel,
	input wire logic        fetch_valid,
	input wire logic [23:0] fetch_addr,
	input wire logic        pc_load,
	input wire logic [15:0] pc_value
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////////////
	sequence s_fetch_pair;
		fetch_valid && !fetch_addr[0] ##1 fetch_valid && fetch_addr[0];
	endsequence
	sequence s_load_slot;
		!pc_load ##1 pc_load;
	endsequence
////////////////////////////////////////////////////////////////////////////////
	a_accept_at_boundary: assert property (push_valid && !$past(push_valid) |-> $past(instr_done))
		else $error("stacking began off an instruction boundary");
	a_bank_then_pc: assert property (push_valid && push_sel == PUSH_CB |-> max_mode ##1 push_valid && push_sel == PUSH_PC)
		else $error("code bank push out of order");
	a_pc_then_flags: assert property (push_valid && push_sel == PUSH_PC |=> push_valid && push_sel == PUSH_SC)
		else $error("flag push did not follow pc push");
	a_flags_then_fetch: assert property (push_valid && push_sel == PUSH_SC |=> s_fetch_pair)
		else $error("vector fetch did not follow stacking");
	a_fetch_then_load: assert property (fetch_valid && fetch_addr[0] |=> s_load_slot)
		else $error("pc load misplaced after vector fetch");
	a_pc_from_bytes: assert property (pc_load |-> pc_value == {$past(fetch_rdata), $past(fetch_rdata, 2)})
		else $error("pc value not built from vector bytes");
	a_vector_window: assert property (fetch_valid |-> fetch_addr[23:8] == 16'h0 && fetch_addr[7:1] != 7'h12)
		else $error("vector fetch outside table or at reserved entry");
	a_irq_for_level: assert property (req_level inside {3'h1, 3'h2, 3'h3} |-> irq)
		else $error("request level without interrupt line");
	a_read_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
endmodule : ivc_asserts

// [verif/ivc_core_model.sv]
/* Vector memory on the core side of the controller.
   Assumes one byte is asked per cycle and answered one cycle later. */
`timescale 1ns/100ps

module ivc_core_model (
	input  wire logic        aclk,
	input  wire logic        fetch_valid,
	input  wire logic [23:0] fetch_addr,
	output logic      [7:0]  fetch_rdata = 8'h5a
);
	// Entries point into the common area so shared routines stay reachable from any bank
	always @(posedge aclk) begin
		if (fetch_valid) begin
			fetch_rdata <= {1'h0, fetch_addr[6:0] ^ 7'h25};
		end else begin
			// Released bus: show a changing value, never the last byte
			fetch_rdata <= ~fetch_rdata;
		end
	end
endmodule : ivc_core_model

// [verif/ivc_top_test.sv]
/* Self-checking bench of the interrupt vector controller.
   Drives AXI4-Lite and core-side pulses; the core model answers vector fetches. */
`timescale 1ns/100ps

module ivc_top_test;
	import ivc_pkg::*;
	logic        aclk = 1'h0, aresetn = 1'h0;
	logic [17:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
	logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic [14:0] factor_evt = '0;
	logic        nmi_evt = 1'h0, zdiv_evt = 1'h0, swi_evt = 1'h0, instr_done = 1'h0;
	logic        max_mode = 1'h0, return_from_exception = 1'h0, core_mask_wr = 1'h0;
	logic [1:0]  core_mask_wdata = '0, s_axi_bresp, s_axi_rresp, core_mask, push_sel;
	logic [7:0]  swi_vec = '0, fetch_rdata;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        irq, push_valid, fetch_valid, pc_load;
	logic [2:0]  req_level;
	logic [23:0] fetch_addr;
	logic [15:0] pc_value;
	logic [7:0]  rb [6] = '{8'hff, 8'h0f, 8'h7f, 8'hff, 8'h00, 8'h00};
	int          error_cnt = 0, tests_run = 0, pushes = 0;

	ivc_top #(.ADDR_W(18)) i_ivc_top (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.factor_evt, .nmi_evt, .zdiv_evt, .swi_evt, .swi_vec, .instr_done, .max_mode,
		.return_from_exception, .core_mask_wr, .core_mask_wdata, .fetch_rdata, .core_mask, .irq,
		.req_level, .push_valid, .push_sel, .fetch_valid, .fetch_addr, .pc_load, .pc_value
	);
	ivc_core_model i_ivc_core_model (.aclk, .fetch_valid, .fetch_addr, .fetch_rdata);

	always #20 aclk = ~aclk;
	always @(posedge aclk) if (push_valid === 1'h1) pushes <= pushes + 1;
////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] vb(input logic [7:0] a);
		return {1'h0, a[6:0] ^ 7'h25};
	endfunction : vb

	task automatic summarize();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			error_cnt++;
		end
	endtask : chk

	task automatic tmo(input int n);
		if (n >= 60) begin
			error_cnt++;
			summarize();
		end
	endtask : tmo

	// Both channels offered together; each dropped only once taken
	task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid && n < 60);
		tmo(n);
		chk(s_axi_bresp, er);
	endtask : wr

	task automatic rd(input logic [15:0] idx, input logic [7:0] exp, input logic [1:0] er);
		int n;
		n = 0;
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid && n < 60);
		tmo(n);
		chk(s_axi_rdata, {24'h0, exp});
		chk(s_axi_rresp, er);
	endtask : rd

	// w: 0 factors, 1 watchdog, 2 zero division, 3 software, 4 return, 5 mask write
	task automatic pulse(input int w, input logic [14:0] m);
		factor_evt <= w == 0 ? m : 15'h0;
		nmi_evt <= w == 1;
		zdiv_evt <= w == 2;
		swi_evt <= w == 3;
		return_from_exception <= w == 4;
		core_mask_wr <= w == 5;
		core_mask_wdata <= m[1:0];
		swi_vec <= m[7:0];
		@(posedge aclk);
		factor_evt <= 15'h0;
		{nmi_evt, zdiv_evt, swi_evt, return_from_exception, core_mask_wr} <= 5'h0;
		repeat (2) @(posedge aclk);
	endtask : pulse

	task automatic wt(input int k);
		int n;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!(k == 0 ? push_valid : k == 1 ? fetch_valid : pc_load) && n < 60);
		tmo(n);
	endtask : wt

	task automatic exc(input logic [7:0] v, input logic [1:0] m);
		instr_done <= 1'h1;
		wt(0);
		instr_done <= 1'h0;
		chk(push_sel, max_mode ? PUSH_CB : PUSH_PC);
		wt(1);
		chk(fetch_addr, {16'h0, v});
		wt(2);
		chk(pc_value, {vb(v + 8'h01), vb(v)});
		chk(core_mask, m);
	endtask : exc

	task automatic quiet();
		int p;
		p = pushes;
		instr_done <= 1'h1;
		repeat (10) @(posedge aclk);
		instr_done <= 1'h0;
		repeat (3) @(posedge aclk);
		chk(32'(pushes), 32'(p));
	endtask : quiet
////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		wt(2);
		chk(pc_value, {vb(8'h01), vb(8'h00)});
		chk(core_mask, 2'h3);
		$display("test reset_vector done");
		for (int i = 0; i < 6; i++) rd(16'(16'hff20 + i), 8'h00, RESP_OKAY);
		for (int i = 0; i < 6; i++) wr(16'(16'hff20 + i), 8'hff, RESP_OKAY);
		for (int i = 0; i < 6; i++) rd(16'(16'hff20 + i), rb[i], RESP_OKAY);
		s_axi_wstrb <= 4'h0;
		wr(16'hff20, 8'h00, RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rd(16'hff20, 8'hff, RESP_OKAY);
		rd(16'hff26, 8'h00, RESP_SLVERR);
		wr(16'hff1f, 8'h00, RESP_SLVERR);
		$display("test registers done");
		pulse(0, 15'h7fff);
		rd(16'hff24, 8'h7f, RESP_OKAY);
		wr(16'hff25, 8'h00, RESP_OKAY);
		rd(16'hff25, 8'hff, RESP_OKAY);
		chk(irq, 1'h1);
		chk(req_level, 3'h3);
		wr(16'hff23, 8'h00, RESP_OKAY);
		wr(16'hff22, 8'h00, RESP_OKAY);
		repeat (2) @(posedge aclk);
		chk(irq, 1'h0);
		wr(16'hff23, 8'hff, RESP_OKAY);
		wr(16'hff22, 8'h7f, RESP_OKAY);
		$display("test flags done");
		pulse(5, 15'h0);
		for (int k = 14; k >= 0; k--) begin
			exc(8'(6 + 2 * (14 - k)), 2'h3);
			wr(k > 6 ? 16'hff25 : 16'hff24, 8'h01 << (k > 6 ? k - 7 : k), RESP_OKAY);
			pulse(4, 15'h0);
			chk(core_mask, 2'h0);
		end
		chk(irq, 1'h0);
		$display("test vector order done");
		wr(16'hff20, 8'h00, RESP_OKAY);
		wr(16'hff21, 8'h08, RESP_OKAY);
		pulse(5, 15'h2);
		pulse(0, 15'h5000);
		chk(req_level, 3'h2);
		quiet();
		pulse(5, 15'h1);
		exc(8'h06, 2'h2);
		pulse(4, 15'h0);
		chk(core_mask, 2'h1);
		exc(8'h06, 2'h2);
		wr(16'hff25, 8'h80, RESP_OKAY);
		pulse(4, 15'h0);
		pulse(5, 15'h0);
		quiet();
		wr(16'hff25, 8'h20, RESP_OKAY);
		$display("test levels done");
		pulse(5, 15'h3);
		max_mode <= 1'h1;
		pulse(1, 15'h0);
		chk(req_level, 3'h4);
		exc(8'h04, 2'h3);
		pulse(4, 15'h0);
		max_mode <= 1'h0;
		pulse(2, 15'h0);
		exc(8'h02, 2'h3);
		pulse(4, 15'h0);
		pulse(3, 15'h24);
		quiet();
		for (int i = 0; i < 2; i++) begin
			pulse(3, i ? 15'hfe : 15'h26);
			exc(i ? 8'hfe : 8'h26, 2'h3);
			pulse(4, 15'h0);
		end
		$display("test exceptions done");
		summarize();
	end
endmodule : ivc_top_test

bind ivc_top ivc_asserts i_ivc_asserts (
	.aclk, .aresetn, .s_axi_rvalid, .s_axi_rdata, .instr_done, .max_mode, .fetch_rdata, .irq,
	.req_level, .push_valid, .push_sel, .fetch_valid, .fetch_addr, .pc_load, .pc_value
);
